// file: flash_sec_regs.svh
`ifndef FLASH_SEC_REGS_SVH
`define FLASH_SEC_REGS_SVH

// Reset sequencer windows, 32 system clocks each
`define SEQ_LAST 5'h1f

// Test port instruction register
`define IR_WIDTH 4
`define IR_CAPTURE 4'h1
`define IR_IDCODE 4'h2
`define IR_LOCKOUT 4'h8
`define IR_BYPASS 4'hf

// Identification code, value is arbitrary
`define IDCODE_VALUE 32'h0000_1001
`define DR_WIDTH 32
`define LOCKOUT_DR_WIDTH 7

// Divider field layout
`define DIV_PRESCALE_BIT 6
`define DIV_RATIO_MSB 5
`define PRESCALE_LAST 3'h7

// Combined value of the two security bytes that means secured
`define SECURE_WORD 16'he70a

// Width of the timing-clock period monitor
`define GAP_WIDTH 11

`endif

// file: flash_sec_pkg.sv
package flash_sec_pkg;
  `include "flash_sec_regs.svh"

  typedef enum logic [3:0] {
    tlr, rti, sel_dr, cap_dr, sh_dr, ex1_dr, pa_dr, ex2_dr, upd_dr,
    sel_ir, cap_ir, sh_ir, ex1_ir, pa_ir, ex2_ir, upd_ir
  } tap_state_type;

  typedef enum logic [1:0] {seq_clocking, seq_periph, seq_core, seq_run} reset_phase_type;

  typedef struct packed {
    logic prescale_by_eight;
    logic [5:0] ratio;
  } flash_div_type;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } jtag_pins_type;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_cmd_type;
endpackage

// file: flash_security_lockout_recovery.sv
`include "flash_sec_regs.svh"

// Function
// [R1] Secured state persists over resets and power-down until flash is erased.
// [R2] Only the two dedicated security bytes decide secured versus unsecured.
// [R3] Secured disables debug emulation; normal fetch and execution unchanged.
// [R4] Boot selects unsecured mode or secure mode with debug emulation port off.
// [R5] Chip test access port works after boot in both modes.
// [R6] Memory read inhibit for the debug port is set at reset from security bytes.
// [R7] Lockout recovery erases the whole flash, which unsecures the device.
// [R8] Lockout instruction selects a 7-bit data register holding the erase clock divider.
// [R9] During recovery that register value overrides the normal flash clock divider.
// [R10] Divider bit 6 drives divide-by-eight prescale, bits 5..0 drive the ratio.
// [R11] Host picks divider values giving a 150 to 200 kHz timing clock.
// [R12] Host sets prescale above a 12.8 MHz flash input clock, clears it below.
// [R13] Flash input clock is system clock over two; timing clock is that over ratio+1.
// [R14] Host loads lockout instruction first, then the divider data register.
// [R15] Erase starts on entering Run-Test/Idle after update; host stays there until done.
// [R16] After recovery host resets the test controller and applies a chip reset.
// [R17] Backdoor key unsecuring works only while backdoor key enable is set.
// [R18] Programming agent writes key first, code second, security bytes last.
// [R19] Reset sequencer has a 32-clock window applying flash security before core init.
// [R20] Internal reset release always happens on a rising system clock edge.
// [R21] While inhibited, debug memory commands return no data and change nothing.
module flash_security_lockout_recovery
  import flash_sec_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire jtag_pins_type jtag_pins_in,
  input wire logic [15:0] security_word_in,
  input wire flash_div_type flash_clock_divider_reg_in,
  input wire logic backdoor_key_enable_in,
  input wire logic key_match_in,
  input wire logic flash_erase_done_in,
  input wire mem_cmd_type dbg_mem_cmd_in,
  input wire logic [15:0] flash_rdata_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  output logic mass_erase_out,
  output logic recovery_done_out,
  output logic flash_timing_tick_out,
  output flash_div_type flash_div_out,
  output logic secure_mode_out,
  output logic mem_read_inhibit_out,
  output logic debug_emulation_enable_out,
  output mem_cmd_type mem_cmd_out,
  output logic [15:0] dbg_rdata_out,
  output logic periph_reset_n_out,
  output logic core_reset_n_out
);

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; test port pins are asynchronous to the system clock
  jtag_pins_type pin_meta_r, pin_sync_r;
  logic tck_prev_r;
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      // Idle pin levels, so no false test reset follows chip reset
      pin_meta_r <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b1};
      pin_sync_r <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b1};
      tck_prev_r <= 1'b0;
    end else begin
      pin_meta_r <= jtag_pins_in;
      pin_sync_r <= pin_meta_r;
      tck_prev_r <= pin_sync_r.tck;
    end
  end
  wire tck_rise = pin_sync_r.tck & ~tck_prev_r;
  wire tck_fall = ~pin_sync_r.tck & tck_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencer: clocking, peripheral/security, core windows
  reset_phase_type phase_r;
  logic [4:0] seq_cnt_r;
  logic secure_r;
  wire seq_window_end = (seq_cnt_r == `SEQ_LAST);
  wire latch_security = (phase_r == seq_periph) && seq_window_end;
  wire sec_word_secure = (security_word_in == `SECURE_WORD); // [R2]
  wire backdoor_unlock = key_match_in && backdoor_key_enable_in && (phase_r == seq_run); // [R17]

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin // [R20]
      phase_r <= seq_clocking;
      seq_cnt_r <= 5'h00;
    end else if (phase_r != seq_run) begin // [R19]
      seq_cnt_r <= seq_cnt_r + 5'h01;
      if (seq_window_end) begin
        phase_r <= reset_phase_type'(phase_r + 2'h1);
      end
    end
  end

  // Secure by default until the bytes are sampled, so nothing leaks early
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      secure_r <= 1'b1;
    end else if (latch_security) begin
      secure_r <= sec_word_secure; // [R1] [R6] [R4]
    end else if (backdoor_unlock) begin
      secure_r <= 1'b0; // [R17]
    end
  end

  assign periph_reset_n_out = (phase_r != seq_clocking);
  assign core_reset_n_out = (phase_r == seq_run);
  assign secure_mode_out = secure_r; // [R4]
  assign mem_read_inhibit_out = secure_r; // [R6]
  assign debug_emulation_enable_out = ~secure_r; // [R3]

  ////////////////////////////////////////////////////////////////////////////
  // Debug memory path; program fetch never passes through here
  logic [15:0] dbg_rdata_r;
  assign mem_cmd_out = secure_r ? '0 : dbg_mem_cmd_in; // [R21] [R3]
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      dbg_rdata_r <= 16'h0000;
    end else begin
      dbg_rdata_r <= secure_r ? 16'h0000 : flash_rdata_in; // [R21]
    end
  end
  assign dbg_rdata_out = dbg_rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Test access port controller, alive in both modes
  tap_state_type tap_r, tap_nxt;
  always_comb begin
    unique case (tap_r)
      tlr: tap_nxt = pin_sync_r.tms ? tlr : rti;
      rti: tap_nxt = pin_sync_r.tms ? sel_dr : rti;
      sel_dr: tap_nxt = pin_sync_r.tms ? sel_ir : cap_dr;
      cap_dr: tap_nxt = pin_sync_r.tms ? ex1_dr : sh_dr;
      sh_dr: tap_nxt = pin_sync_r.tms ? ex1_dr : sh_dr;
      ex1_dr: tap_nxt = pin_sync_r.tms ? upd_dr : pa_dr;
      pa_dr: tap_nxt = pin_sync_r.tms ? ex2_dr : pa_dr;
      ex2_dr: tap_nxt = pin_sync_r.tms ? upd_dr : sh_dr;
      upd_dr: tap_nxt = pin_sync_r.tms ? sel_dr : rti;
      sel_ir: tap_nxt = pin_sync_r.tms ? tlr : cap_ir;
      cap_ir: tap_nxt = pin_sync_r.tms ? ex1_ir : sh_ir;
      sh_ir: tap_nxt = pin_sync_r.tms ? ex1_ir : sh_ir;
      ex1_ir: tap_nxt = pin_sync_r.tms ? upd_ir : pa_ir;
      pa_ir: tap_nxt = pin_sync_r.tms ? ex2_ir : pa_ir;
      ex2_ir: tap_nxt = pin_sync_r.tms ? upd_ir : sh_ir;
      upd_ir: tap_nxt = pin_sync_r.tms ? sel_dr : rti;
    endcase
  end

  logic [`IR_WIDTH-1:0] ir_shift_r, ir_r;
  logic [`DR_WIDTH-1:0] dr_shift_r;
  flash_div_type jtag_flash_divider_value_r;
  logic armed_r, tdo_r, tdo_oe_r;
  wire lockout_sel = (ir_r == `IR_LOCKOUT);
  wire tap_reset = ~pin_sync_r.trst_n;

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in || tap_reset) begin // [R5]
      tap_r <= tlr;
    end else if (tck_rise) begin
      tap_r <= tap_nxt;
    end
  end

  // Instruction and data shift paths
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in || tap_reset || (tap_r == tlr)) begin
      ir_shift_r <= `IR_CAPTURE;
      ir_r <= `IR_IDCODE;
      dr_shift_r <= '0;
    end else if (tck_rise) begin
      unique case (tap_r)
        cap_ir: ir_shift_r <= `IR_CAPTURE;
        sh_ir: ir_shift_r <= {pin_sync_r.tdi, ir_shift_r[`IR_WIDTH-1:1]};
        upd_ir: ir_r <= ir_shift_r; // [R14]
        cap_dr: dr_shift_r <= (ir_r == `IR_IDCODE) ? `IDCODE_VALUE :
                              lockout_sel ? {25'h0, jtag_flash_divider_value_r} : '0;
        sh_dr: begin
          if (ir_r == `IR_IDCODE) begin
            dr_shift_r <= {pin_sync_r.tdi, dr_shift_r[`DR_WIDTH-1:1]};
          end else if (lockout_sel) begin // [R8]
            dr_shift_r <= {25'h0, pin_sync_r.tdi, dr_shift_r[`LOCKOUT_DR_WIDTH-1:1]};
          end else begin
            dr_shift_r <= {31'h0, pin_sync_r.tdi};
          end
        end
        default: ir_shift_r <= ir_shift_r;
      endcase
    end
  end

  // TDO changes on the falling test clock, as the host samples on the rising one
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_r <= (tap_r == sh_ir) ? ir_shift_r[0] : dr_shift_r[0];
      tdo_oe_r <= (tap_r == sh_ir) || (tap_r == sh_dr);
    end
  end
  assign tdo_out = tdo_r;
  assign tdo_oe_out = tdo_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Lockout recovery: divider load, erase start and completion
  logic erase_r, done_r;
  wire dr_update = tck_rise && (tap_r == upd_dr) && lockout_sel;
  wire enter_rti = tck_rise && (tap_r != rti) && (tap_nxt == rti);
  // Leaving Update-DR for idle is one test clock edge, so the update itself also arms
  wire erase_start = enter_rti && (armed_r || dr_update) && lockout_sel && !erase_r;

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      jtag_flash_divider_value_r <= '0;
      armed_r <= 1'b0;
    end else begin
      if (dr_update) begin
        jtag_flash_divider_value_r <= dr_shift_r[`LOCKOUT_DR_WIDTH-1:0]; // [R8]
      end
      if (erase_start || tap_reset) begin
        armed_r <= 1'b0;
      end else if (dr_update) begin
        armed_r <= 1'b1;
      end
    end
  end

  // Erase runs to completion even if the host leaves the idle state early
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      erase_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      if (erase_start) begin
        erase_r <= 1'b1; // [R15] [R7]
      end else if (flash_erase_done_in) begin
        erase_r <= 1'b0;
      end
      if (erase_r && flash_erase_done_in) begin
        done_r <= 1'b1; // [R16]
      end else if (tap_reset) begin
        done_r <= 1'b0;
      end
    end
  end
  assign mass_erase_out = erase_r; // [R7]
  assign recovery_done_out = done_r;

  ////////////////////////////////////////////////////////////////////////////
  // Flash timing clock: input clock is half the system clock
  logic fin_phase_r, tick_r;
  logic [2:0] pre_cnt_r;
  logic [5:0] ratio_cnt_r;
  assign flash_div_out = lockout_sel ? jtag_flash_divider_value_r : flash_clock_divider_reg_in; // [R9]
  wire fin_en = fin_phase_r; // [R13]
  wire pre_en = fin_en && (!flash_div_out.prescale_by_eight || (pre_cnt_r == `PRESCALE_LAST)); // [R10]
  wire ratio_wrap = pre_en && (ratio_cnt_r >= flash_div_out.ratio); // [R10] [R13]

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      fin_phase_r <= 1'b0;
      pre_cnt_r <= 3'h0;
      ratio_cnt_r <= 6'h00;
      tick_r <= 1'b0;
    end else begin
      fin_phase_r <= ~fin_phase_r;
      if (!flash_div_out.prescale_by_eight) begin
        pre_cnt_r <= 3'h0;
      end else if (fin_en) begin
        pre_cnt_r <= pre_cnt_r + 3'h1;
      end
      if (ratio_wrap) begin
        ratio_cnt_r <= 6'h00;
      end else if (pre_en) begin
        ratio_cnt_r <= ratio_cnt_r + 6'h01;
      end
      tick_r <= ratio_wrap;
    end
  end
  assign flash_timing_tick_out = tick_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [`GAP_WIDTH-1:0] gap_r;
  logic gap_valid_r;
  wire [`GAP_WIDTH-1:0] ratio_p1 = {5'h00, flash_div_out.ratio} + 11'h001;
  wire [`GAP_WIDTH-1:0] exp_gap = flash_div_out.prescale_by_eight ? (ratio_p1 << 4) : (ratio_p1 << 1);
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      gap_r <= 11'h001;
      gap_valid_r <= 1'b0;
    end else begin
      gap_r <= tick_r ? 11'h001 : gap_r + 11'h001;
      if (flash_div_out != $past(flash_div_out)) begin
        gap_valid_r <= 1'b0;
      end else if (tick_r) begin
        gap_valid_r <= 1'b1;
      end
    end
  end

  sequence periph_released;
    $rose(periph_reset_n_out);
  endsequence
  sequence core_after_windows;
    ##64 $rose(core_reset_n_out);
  endsequence

  a_core_init_window: assert property (periph_released |-> core_after_windows) // [R19]
    else $error("core released at wrong time after peripherals");
  a_security_latched: assert property (latch_security |=> secure_mode_out == $past(sec_word_secure)) // [R6]
    else $error("security state not taken from security bytes");
  a_debug_cmd_blocked: assert property (secure_mode_out |-> !mem_cmd_out.req && !debug_emulation_enable_out) // [R21]
    else $error("debug memory command passed while secured");
  a_rdata_blocked: assert property (secure_mode_out && $past(secure_mode_out) |-> dbg_rdata_out == 16'h0000) // [R21]
    else $error("flash data returned while secured");
  a_erase_on_idle: assert property (erase_start |=> mass_erase_out throughout (!flash_erase_done_in)[*1]) // [R15]
    else $error("erase did not start on entry to idle");
  a_div_override: assert property (lockout_sel |-> flash_div_out == jtag_flash_divider_value_r) // [R9]
    else $error("lockout divider not applied");
  a_timing_period: assert property (tick_r && gap_valid_r && $stable(flash_div_out) |-> gap_r == exp_gap) // [R13]
    else $error("flash timing clock period wrong");
  a_backdoor_refused: assert property (secure_mode_out && !backdoor_key_enable_in && !latch_security
                                       |=> secure_mode_out) // [R17]
    else $error("backdoor unlock accepted without key enable");
  a_tap_trst: assert property (tap_reset |=> tap_r == tlr) // [R5]
    else $error("test controller not reset by test reset");

endmodule

// file: jtag_host_model.sv
module jtag_host_model
  import flash_sec_pkg::*;
(
  input wire logic mclk_in,
  input wire logic tdo_in,
  output jtag_pins_type pins_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial pins_out = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b1};

  ////////////////////////////////////////////////////////////////////////
  // One test clock period, 6 system clocks per phase so the 2-flop sync keeps up
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(negedge mclk_in);
    pins_out.tms = tms;
    pins_out.tdi = tdi;
    pins_out.tck = 1'b0;
    repeat (6) @(negedge mclk_in);
    tdo = tdo_in;
    pins_out.tck = 1'b1;
    repeat (5) @(negedge mclk_in);
  endtask

  // Test reset pin, then park in Run-Test/Idle
  task automatic reset_tap();
    logic b;
    @(negedge mclk_in);
    pins_out.trst_n = 1'b0;
    repeat (8) @(negedge mclk_in);
    pins_out.trst_n = 1'b1;
    step(1'b0, 1'b0, b);
  endtask

  // Scan from Run-Test/Idle back to it, LSB first; test clock then stops in idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic b;
    dout = '0;
    step(1'b1, 1'b0, b);
    if (ir) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask
endmodule

// file: tb_top.sv
`include "flash_sec_regs.svh"
module tb_top
  import flash_sec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  jtag_pins_type jtag_pins;
  logic [15:0] sec_word = `SECURE_WORD;
  flash_div_type div_reg = '{prescale_by_eight: 1'b0, ratio: 6'h01};
  logic key_en = 1'b0;
  logic key_match = 1'b0;
  logic erase_done = 1'b0;
  mem_cmd_type cmd = '0;
  logic [15:0] frd = 16'h0000;
  logic tdo, tdo_oe, mass, done, tick, secure, inhibit, emul, rst_p_n, rst_c_n;
  flash_div_type div_out;
  mem_cmd_type cmd_out;
  logic [15:0] rdata;
  int error_cnt = 0;
  int samples_checked = 0;

  always #2.5 mclk_in = ~mclk_in;

  jtag_host_model host (.mclk_in(mclk_in), .tdo_in(tdo), .pins_out(jtag_pins));

  flash_security_lockout_recovery uut (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .jtag_pins_in(jtag_pins), .security_word_in(sec_word),
    .flash_clock_divider_reg_in(div_reg), .backdoor_key_enable_in(key_en), .key_match_in(key_match),
    .flash_erase_done_in(erase_done), .dbg_mem_cmd_in(cmd), .flash_rdata_in(frd), .tdo_out(tdo),
    .tdo_oe_out(tdo_oe), .mass_erase_out(mass), .recovery_done_out(done), .flash_timing_tick_out(tick),
    .flash_div_out(div_out), .secure_mode_out(secure), .mem_read_inhibit_out(inhibit),
    .debug_emulation_enable_out(emul), .mem_cmd_out(cmd_out), .dbg_rdata_out(rdata),
    .periph_reset_n_out(rst_p_n), .core_reset_n_out(rst_c_n));

  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return rst_p_n === 1'b1;
      1: return rst_c_n === 1'b1;
      2: return tick === 1'b1;
      3: return mass === 1'b1;
      default: return mass === 1'b0;
    endcase
  endfunction

  // Bounded wait, counts rising edges until the chosen output is seen
  task automatic wait_sig(input int sel, input int lim, output int n);
    n = 0;
    do begin
      @(posedge mclk_in);
      #1;
      n++;
    end while (!pick(sel) && n < lim);
    if (!pick(sel)) begin
      error_cnt++;
      $display("BAD %0t timeout waiting", $time);
      tally_and_finish();
    end
  endtask

  task automatic period(output int n);
    int m;
    wait_sig(2, 2000, m);
    wait_sig(2, 2000, n);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic chip_reset(input logic [15:0] w, input logic exp_sec);
    int a, b;
    @(negedge mclk_in);
    reset_n_in = 1'b0;
    sec_word = w;
    repeat (16) @(negedge mclk_in);
    reset_n_in = 1'b1;
    wait_sig(0, 100, a);
    chk(a == 32 || a == 33, 1);
    wait_sig(1, 200, b);
    chk(b, 64);
    chk(secure, exp_sec);
    chk(inhibit, exp_sec);
    chk(emul, !exp_sec);
  endtask

  // Read and write both tried; a secured part must pass neither
  task automatic sc_mem(input logic sec);
    for (int we = 0; we < 2; we++) begin
      @(negedge mclk_in);
      cmd = '{req: 1'b1, we: we[0], addr: 16'h0123, wdata: 16'h5a5a};
      frd = 16'ha5c3;
      #1 chk(cmd_out, sec ? 34'h0 : cmd);
      @(posedge mclk_in);
      #1 chk(rdata, sec ? 16'h0000 : 16'ha5c3);
    end
    @(negedge mclk_in);
    cmd = '0;
  endtask

  task automatic sc_idcode();
    logic [31:0] d;
    host.reset_tap();
    host.scan(1'b1, `IR_WIDTH, `IR_IDCODE, d);
    chk(d[3:0], `IR_CAPTURE);
    host.scan(1'b0, `DR_WIDTH, 32'h0, d);
    chk(d, `IDCODE_VALUE);
    chk(tdo_oe, 1'b0);
    host.scan(1'b1, `IR_WIDTH, `IR_BYPASS, d);
    host.scan(1'b0, 2, 32'h1, d);
    chk(d[1:0], 2'b10);
  endtask

  task automatic sc_backdoor();
    @(negedge mclk_in);
    key_match = 1'b1;
    repeat (4) @(negedge mclk_in);
    chk(secure, 1'b1);
    key_en = 1'b1;
    @(posedge mclk_in);
    #1 chk({secure, inhibit, emul}, 3'b001);
    @(negedge mclk_in);
    key_match = 1'b0;
    key_en = 1'b0;
  endtask

  task automatic sc_lockout();
    logic [31:0] d;
    int n;
    period(n);
    chk(n, 4);
    host.reset_tap();
    host.scan(1'b1, `IR_WIDTH, `IR_LOCKOUT, d);
    // 100 MHz flash input needs prescale and the top ratio to land near 195 kHz
    host.scan(1'b0, `LOCKOUT_DR_WIDTH, 32'h7f, d);
    wait_sig(3, 100, n);
    chk(div_out, 7'h7f);
    period(n);
    chk(n, 1024);
    @(negedge mclk_in);
    erase_done = 1'b1;
    @(negedge mclk_in);
    erase_done = 1'b0;
    wait_sig(4, 3, n);
    chk(done, 1'b1);
    chk(secure, 1'b1);
    host.reset_tap();
    chk(done, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    chip_reset(`SECURE_WORD, 1'b1);
    sc_mem(1'b1);
    sc_idcode();
    sc_backdoor();
    chip_reset(`SECURE_WORD, 1'b1);
    sc_lockout();
    chip_reset(16'hffff, 1'b0);
    sc_mem(1'b0);
    chip_reset(`SECURE_WORD ^ 16'h0100, 1'b0);
    tally_and_finish();
  end
endmodule
